// ===== core/rtc_keyed_special_config.sv
// The implementer's own choice: the address-and-strobe port.
`include "rtc_keyed_consts.svh"

// How it works
// RULE1: first key reads zero, accepts 0x5E
// RULE2: second key reads zero, accepts 0xC7
// RULE3: guarded write needs both keys in order
// RULE4: host writes keys before every guarded write
// RULE5: reset clears one hertz select, 512 Hz
// RULE6: one hertz select gives trimmed 1 Hz
// RULE7: 512 Hz output carries no trim
// RULE8: FET bypass follows config bit
// RULE9: host writes zero to reserved bits
// RULE10: one unlock covers exactly one write
// RULE11: wrong or misordered key restarts sequence
module rtc_keyed_special_config
	import rtc_keyed_pkg::*;
(
	// Clock and reset
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_IN,
	// Register port
	input  wire logic [7:0]  ADDR_IN,
	input  wire logic [7:0]  WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic      [7:0]  RDATA_OUT,
	// Block outputs
	output logic             FET_BYPASS_OUT,
	output logic      [3:0]  TRICKLE_CHARGE_ENABLE_OUT,
	output logic             CAL_WAVE_OUT,
	output logic             ONE_HZ_OUT
);

	// -----------------------------------------------------------
	// State
	// -----------------------------------------------------------
	logic [7:0] config_two_q;
	logic [7:0] config_two_d;
	logic [7:0] guarded_q;
	logic [7:0] guarded_d;
	logic [7:0] out_ctrl_q;
	logic [7:0] out_ctrl_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       fet_q;
	logic [3:0] trickle_charge_enable_field_q;
	logic       wave_q;
	logic       one_hz_q;
	logic       unlock_open;
	logic       unlock_half;
	logic       cal_wave;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction : hit

	// -----------------------------------------------------------
	// Key sequencing
	// -----------------------------------------------------------
	key_sequencer u_keys (
		.clk_in   (REF_CLK_IN),
		.rst_in   (RST_IN),
		.wr_in    (WR_IN),
		.addr_in  (ADDR_IN),
		.data_in  (WDATA_IN),
		.open_out (unlock_open),
		.half_out (unlock_half)
	);

	// -----------------------------------------------------------
	// Register writes
	// -----------------------------------------------------------
	// Reserved bits are masked so a careless host cannot set them
	always_comb begin
		config_two_d = config_two_q;
		guarded_d    = guarded_q;
		out_ctrl_d   = out_ctrl_q;
		if (WR_IN) begin
			if (hit(ADDR_IN, `OFS_CONFIG_TWO))
				config_two_d = WDATA_IN & `CONFIG_TWO_WMASK; // RULE9
			if (hit(ADDR_IN, `OFS_GUARDED) && unlock_open)
				guarded_d = WDATA_IN & `GUARDED_WMASK; // RULE3 RULE10
			if (hit(ADDR_IN, `OFS_OUT_CTRL))
				out_ctrl_d = WDATA_IN & 8'h3F;
		end
	end

	// -----------------------------------------------------------
	// Register reads
	// -----------------------------------------------------------
	always_comb begin
		rdata_d = `READ_ZERO; // RULE1 RULE2
		if (RD_IN) begin
			if (hit(ADDR_IN, `OFS_CONFIG_TWO))
				rdata_d = config_two_q;
			else if (hit(ADDR_IN, `OFS_GUARDED))
				rdata_d = guarded_q;
			else if (hit(ADDR_IN, `OFS_OUT_CTRL))
				rdata_d = out_ctrl_q;
			else if (hit(ADDR_IN, `OFS_UNLOCK_STAT))
				rdata_d = {6'h00, unlock_open, unlock_half};
		end
	end

	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			config_two_q <= `CONFIG_TWO_RST;
			guarded_q    <= `GUARDED_RST; // RULE5
			out_ctrl_q   <= `OUT_CTRL_RST;
			rdata_q      <= `READ_ZERO;
		end else begin
			config_two_q <= config_two_d;
			guarded_q    <= guarded_d;
			out_ctrl_q   <= out_ctrl_d;
			rdata_q      <= rdata_d;
		end
	end

	// -----------------------------------------------------------
	// Calibration output
	// -----------------------------------------------------------
	cal_divider u_cal (
		.clk_in      (REF_CLK_IN),
		.rst_in      (RST_IN),
		.one_hz_in   (guarded_q[`GUARDED_FTF_BIT]), // RULE6
		.cal_amt_in  (out_ctrl_q[4:0]),
		.cal_slow_in (out_ctrl_q[`OUT_CTRL_SLOW_BIT]),
		.wave_out    (cal_wave)
	);

	// -----------------------------------------------------------
	// Output flops
	// -----------------------------------------------------------
	always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			fet_q    <= 1'b0;
			trickle_charge_enable_field_q   <= 4'h0;
			wave_q   <= 1'b0;
			one_hz_q <= 1'b0;
		end else begin
			fet_q    <= config_two_q[`CONFIG_TWO_FET_BIT]; // RULE8
			trickle_charge_enable_field_q   <= config_two_q[`CONFIG_TWO_TRICKLE_CHARGE_ENABLE_FIELD_MSB:`CONFIG_TWO_TRICKLE_CHARGE_ENABLE_FIELD_LSB];
			wave_q   <= cal_wave;
			one_hz_q <= guarded_q[`GUARDED_FTF_BIT];
		end
	end

	assign RDATA_OUT                 = rdata_q;
	assign FET_BYPASS_OUT            = fet_q;
	assign TRICKLE_CHARGE_ENABLE_OUT = trickle_charge_enable_field_q;
	assign CAL_WAVE_OUT              = wave_q;
	assign ONE_HZ_OUT                = one_hz_q;

	// -----------------------------------------------------------
	// Checks
	// -----------------------------------------------------------
	sequence key_pair_s;
		WR_IN && ADDR_IN == `OFS_KEY_FIRST && WDATA_IN == `KEY_FIRST_VAL
		##1 WR_IN && ADDR_IN == `OFS_KEY_SECOND
			&& WDATA_IN == `KEY_SECOND_VAL;
	endsequence

	chk_key_first_read: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		RD_IN && ADDR_IN == `OFS_KEY_FIRST |=> RDATA_OUT == 8'h00) // RULE1
		else $error("first key read nonzero");

	chk_key_second_read: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		RD_IN && ADDR_IN == `OFS_KEY_SECOND |=> RDATA_OUT == 8'h00) // RULE2
		else $error("second key read nonzero");

	chk_guarded_unlock: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		key_pair_s ##1 WR_IN && ADDR_IN == `OFS_GUARDED
		|=> guarded_q == (($past(WDATA_IN)) & 8'h40)) // RULE3
		else $error("unlocked write not taken");

	chk_guarded_locked: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		WR_IN && ADDR_IN == `OFS_GUARDED && !unlock_open
		|=> $stable(guarded_q)) // RULE10
		else $error("locked write changed register");

	chk_single_use: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		WR_IN && ADDR_IN == `OFS_GUARDED |=> !unlock_open) // RULE10
		else $error("unlock reused");

	chk_bad_second_key: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		WR_IN && ADDR_IN == `OFS_KEY_SECOND && WDATA_IN != `KEY_SECOND_VAL
		|=> !unlock_open && !unlock_half) // RULE11
		else $error("wrong key kept progress");

	chk_one_hz_follow: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		$changed(guarded_q) |=> ONE_HZ_OUT == $past(guarded_q[6])) // RULE6
		else $error("one hertz flag lag");

	chk_fet_follow: assert property (@(posedge REF_CLK_IN)
		disable iff (RST_IN)
		WR_IN && ADDR_IN == `OFS_CONFIG_TWO
		|=> ##1 FET_BYPASS_OUT == $past(WDATA_IN[6], 2)) // RULE8
		else $error("FET bypass mismatch");

	chk_reset_select: assert property (@(posedge REF_CLK_IN)
		$fell(RST_IN) |-> !ONE_HZ_OUT && guarded_q == 8'h00) // RULE5
		else $error("select not cleared by reset");

endmodule : rtc_keyed_special_config

// ===== core/rtc_keyed_consts.svh
`ifndef RTC_KEYED_CONSTS_SVH
`define RTC_KEYED_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define OFS_CONFIG_TWO      8'h09
`define OFS_KEY_FIRST       8'h20
`define OFS_KEY_SECOND      8'h21
`define OFS_GUARDED         8'h22
`define OFS_OUT_CTRL        8'h30
`define OFS_UNLOCK_STAT     8'h31

// ---------------------------------------------------------------
// Key values and reset values
// ---------------------------------------------------------------
`define KEY_FIRST_VAL       8'h5E
`define KEY_SECOND_VAL      8'hC7
`define CONFIG_TWO_RST      8'h00
`define GUARDED_RST         8'h00
`define OUT_CTRL_RST        8'h00
`define READ_ZERO           8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CONFIG_TWO_FET_BIT        6
`define CONFIG_TWO_TRICKLE_CHARGE_ENABLE_FIELD_LSB       0
`define CONFIG_TWO_TRICKLE_CHARGE_ENABLE_FIELD_MSB       3
`define CONFIG_TWO_WMASK          8'h4F
`define GUARDED_FTF_BIT     6
`define GUARDED_WMASK       8'h40
`define OUT_CTRL_WMASK      8'h1F
`define OUT_CTRL_SLOW_BIT   5

// ---------------------------------------------------------------
// Timing: 125 MHz reference, 512 Hz and 1 Hz half periods
// ---------------------------------------------------------------
`define CLK_HZ              125000000
`define HALF_512_CYC        (`CLK_HZ / 1024)
`define HALF_1HZ_CYC        (`CLK_HZ / 2)
`define DIV_W               27

`endif

// ===== core/rtc_keyed_pkg.sv
package rtc_keyed_pkg;

	typedef enum logic [2:0] {
		LOCKED   = 3'b001,
		HALF_KEY = 3'b010,
		OPEN     = 3'b100
	} unlock_state_t;

endpackage : rtc_keyed_pkg

// ===== core/cal_divider.sv
`include "rtc_keyed_consts.svh"

module cal_divider
	import rtc_keyed_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Control
	input  wire logic        one_hz_in,
	input  wire logic [4:0]  cal_amt_in,
	input  wire logic        cal_slow_in,
	// Output
	output logic             wave_out
);

	logic [`DIV_W-1:0] cnt_q;
	logic [`DIV_W-1:0] cnt_d;
	logic              wave_q;
	logic              wave_d;
	logic              mode_q;
	logic              mode_d;
	logic [`DIV_W-1:0] limit;

	// Signed ppm trim in cycles, about 62 cycles per ppm at 1 Hz
	function automatic logic [`DIV_W-1:0] trim(input logic [4:0] amt,
			input logic slow);
		logic [`DIV_W-1:0] base;
		logic [`DIV_W-1:0] step;
		base = `DIV_W'(`HALF_1HZ_CYC);
		step = `DIV_W'({amt, 6'h00});
		trim = slow ? base + (step << 1) : base - step;
	endfunction : trim

	always_comb begin
		limit  = one_hz_in ? trim(cal_amt_in, cal_slow_in) // RULE6
			: `DIV_W'(`HALF_512_CYC); // RULE7
		mode_d = one_hz_in;
		cnt_d  = cnt_q + `DIV_W'(1);
		wave_d = wave_q;
		if (mode_q != one_hz_in) begin
			cnt_d  = '0;
			wave_d = 1'b0;
		end else if (cnt_q >= limit - `DIV_W'(1)) begin
			cnt_d  = '0;
			wave_d = ~wave_q;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q  <= '0;
			wave_q <= 1'b0;
			mode_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			wave_q <= wave_d;
			mode_q <= mode_d;
		end
	end

	assign wave_out = wave_q;

endmodule : cal_divider

// ===== core/key_sequencer.sv
`include "rtc_keyed_consts.svh"

module key_sequencer
	import rtc_keyed_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Register writes
	input  wire logic        wr_in,
	input  wire logic [7:0]  addr_in,
	input  wire logic [7:0]  data_in,
	// Status
	output logic             open_out,
	output logic             half_out
);

	unlock_state_t st_q;
	unlock_state_t st_d;

	always_comb begin
		st_d = st_q;
		if (wr_in) begin
			if (addr_in == `OFS_KEY_FIRST && data_in == `KEY_FIRST_VAL)
				st_d = HALF_KEY; // RULE3
			else if (addr_in == `OFS_KEY_SECOND && st_q == HALF_KEY
					&& data_in == `KEY_SECOND_VAL)
				st_d = OPEN; // RULE3
			else
				st_d = LOCKED; // RULE11 RULE10
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in)
			st_q <= LOCKED;
		else
			st_q <= st_d;
	end

	assign open_out = (st_q == OPEN);
	assign half_out = (st_q == HALF_KEY);

	// Partial progress dies on any other write
	chk_key_restart: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_in && addr_in != `OFS_KEY_FIRST && addr_in != `OFS_KEY_SECOND
		|=> st_q == LOCKED) // RULE11
		else $error("unlock survived a foreign write");

endmodule : key_sequencer

// ===== tb/host_model.sv
`include "rtc_keyed_consts.svh"

module host_model (
	// Clock
	input  wire logic       clk_in,
	// Register port
	output logic            wr_out,
	output logic            rd_out,
	output logic [7:0]      addr_out,
	output logic [7:0]      wdata_out,
	input  wire logic [7:0] rdata_in
);
	initial begin
		wr_out    = 1'b0;
		rd_out    = 1'b0;
		addr_out  = 8'h00;
		wdata_out = 8'h00;
	end

	// Called just after an edge, strobes back to back
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		wr_out    <= 1'b1;
		rd_out    <= 1'b0;
		addr_out  <= a;
		wdata_out <= d;
		@(posedge clk_in);
	endtask : put

	// Data stand only in the cycle after the strobe, taken at its end
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		wr_out   <= 1'b0;
		rd_out   <= 1'b1;
		addr_out <= a;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask : get

	task automatic idle();
		wr_out <= 1'b0;
		rd_out <= 1'b0;
		@(posedge clk_in);
	endtask : idle

	// Fresh key pair before every guarded write
	task automatic guarded(input logic [7:0] d);
		put(`OFS_KEY_FIRST, `KEY_FIRST_VAL);
		put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
		put(`OFS_GUARDED, d & `GUARDED_WMASK);
	endtask : guarded
endmodule : host_model

// ===== tb/rtc_keyed_special_config_tb.sv
`include "rtc_keyed_consts.svh"

module rtc_keyed_special_config_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk;
	logic       rst;
	logic       wr;
	logic       rd;
	logic       fet;
	logic       one_hz;
	logic       wave;
	logic       good;
	logic [3:0] tce;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic [7:0] d;
	logic [7:0] v;
	logic [7:0] exp_g;
	int         miscompares;
	int         samples_checked;
	int         seed;
	int         n;

	host_model host_u (.clk_in(clk), .wr_out(wr), .rd_out(rd),
		.addr_out(addr), .wdata_out(wdata), .rdata_in(rdata));

	rtc_keyed_special_config dut_u (.REF_CLK_IN(clk), .RST_IN(rst),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.RDATA_OUT(rdata), .FET_BYPASS_OUT(fet),
		.TRICKLE_CHARGE_ENABLE_OUT(tce), .CAL_WAVE_OUT(wave),
		.ONE_HZ_OUT(one_hz));

	function automatic logic [7:0] next_g(input logic [7:0] old,
		input logic ok, input logic [7:0] w);
		return ok ? (w & `GUARDED_WMASK) : old;
	endfunction : next_g

	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic final_report();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Budget well above the 512 Hz divider count
	initial begin
		#2000000;
		miscompares++;
		final_report();
	end

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		rst = 1'b1;
		seed = 49182;
		miscompares = 0;
		samples_checked = 0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		host_u.get(`OFS_GUARDED, d);
		cmp(d, `GUARDED_RST);
		cmp({7'h00, one_hz}, 8'h00);
		host_u.put(`OFS_KEY_FIRST, `KEY_FIRST_VAL);
		host_u.get(`OFS_KEY_FIRST, d);
		cmp(d, `READ_ZERO);
		host_u.get(`OFS_UNLOCK_STAT, d);
		cmp(d, 8'h01);
		host_u.put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
		host_u.get(`OFS_KEY_SECOND, d);
		cmp(d, `READ_ZERO);
		host_u.get(`OFS_UNLOCK_STAT, d);
		cmp(d, 8'h02);
		for (n = 0; n < 8; n++) begin
			v = $random(seed) & `CONFIG_TWO_WMASK;
			host_u.put(`OFS_CONFIG_TWO, v);
			host_u.get(`OFS_CONFIG_TWO, d);
			cmp(d, v);
			cmp({7'h00, fet}, {7'h00, v[6]});
			cmp({4'h0, tce}, {4'h0, v[3:0]});
		end
		$display("config test done");
		host_u.put(`OFS_GUARDED, 8'h40);
		host_u.get(`OFS_GUARDED, d);
		cmp(d, 8'h00);
		host_u.guarded(8'h40);
		host_u.idle();
		host_u.get(`OFS_GUARDED, d);
		cmp(d, 8'h40);
		cmp({7'h00, one_hz}, 8'h01);
		host_u.put(`OFS_GUARDED, 8'h00);
		host_u.get(`OFS_GUARDED, d);
		cmp(d, 8'h40);
		host_u.put(`OFS_KEY_FIRST, 8'h5F);
		host_u.put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
		host_u.put(`OFS_GUARDED, 8'h00);
		host_u.put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
		host_u.put(`OFS_KEY_FIRST, `KEY_FIRST_VAL);
		host_u.put(`OFS_GUARDED, 8'h00);
		host_u.put(`OFS_KEY_FIRST, `KEY_FIRST_VAL);
		host_u.put(`OFS_CONFIG_TWO, 8'h00);
		host_u.put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
		host_u.put(`OFS_GUARDED, 8'h00);
		host_u.get(`OFS_GUARDED, d);
		cmp(d, 8'h40);
		exp_g = 8'h40;
		for (n = 0; n < 8; n++) begin
			good = $random(seed);
			v = $random(seed);
			host_u.put(`OFS_KEY_FIRST,
				good ? `KEY_FIRST_VAL : (`KEY_FIRST_VAL ^ (v | 8'h01)));
			host_u.put(`OFS_KEY_SECOND, `KEY_SECOND_VAL);
			host_u.put(`OFS_GUARDED, v & `GUARDED_WMASK);
			exp_g = next_g(exp_g, good, v);
			host_u.get(`OFS_GUARDED, d);
			cmp(d, exp_g);
		end
		host_u.get(8'h55, d);
		cmp(d, `READ_ZERO);
		$display("key test done");
		// Full trim must not leak into the fast wave
		host_u.put(`OFS_OUT_CTRL, 8'h1F);
		host_u.get(`OFS_OUT_CTRL, d);
		cmp(d, 8'h1F);
		host_u.guarded(8'h40);
		host_u.guarded(8'h00);
		n = 0;
		while (wave !== 1'b1 && n < 130000) begin
			host_u.idle();
			n++;
		end
		cmp({7'h00, n >= 122066 && n <= 122074}, 8'h01);
		$display("wave test done");
		final_report();
	end
endmodule : rtc_keyed_special_config_tb
